// [fr_host_framer.sv]
// host command framer: frame parsing, command execution and reply coding
// Operation
// - frames are code, length, data; replies likewise
// - echo 0x55 answers 0x55 or ends listening
// - 0x01 returns identification and revision
// - 0x02 selects protocol and stores parameters
// - 0x03 returns external field flag
// - 0x04 transmits data then returns response
// - 0x05 listens, 0x06 sends, card emulation
// - 0x07 waits for chosen wake events
// - 0x08 reads wake event or analog register
// - 0x09 writes analog, index, window, autodetect
// - 0x0b returns last subcarrier frequency
// - 0x0d switches type A anticollision filter
// - receive limit 528 bytes, 256 for type A and card emulation
// - long code bit7 one, bits3:0 zero, bit4 partial in type A and card emulation only
// - 10-bit count split over code and length
// - type B start, guard, turnaround error codes
// - good frame reports 0x80 with count bits 6:5 and partial bit4 set in
// - 0x87 wait expired, 0x88 sof, 0x8e lost
// - 0x89 buffer full, 0x8a framing fault
// - type F 0x8c short, 0x8d checksum
// - 0x8f no field, 0x85 host abort
`timescale 1ns/1ps
`default_nettype none
`include "fr_params.svh"
module fr_host_framer #(
  parameter logic [7:0] ID_CODE = 8'ha5,  // arbitrary value
  parameter logic [7:0] ID_REV  = 8'h01   // arbitrary value
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             rf_tx_valid_o,
  input  wire logic        rf_tx_ready_i,
  output logic      [7:0]  rf_tx_data_o,
  output logic             rf_tx_last_o,
  input  wire logic        rf_rx_valid_i,
  input  wire logic [7:0]  rf_rx_data_i,
  input  wire logic        rf_rx_done_i,
  input  wire logic [3:0]  rf_rx_err_i,
  input  wire logic        rf_rx_partial_i,
  input  wire logic [7:0]  rf_subcarrier_i,
  output logic             rf_listen_o,
  input  wire logic        external_field_flag_i,
  input  wire logic [3:0]  wake_src_i,
  output logic      [7:0]  rf_proto_o,
  output logic      [7:0]  rf_param_o,
  output logic      [7:0]  analog_cfg_o,
  output logic      [7:0]  analog_index_o,
  output logic      [7:0]  type_a_timer_window_o,
  output logic             autodetect_en_o,
  output logic             ac_filter_en_o,
  output logic             low_power_o
);

  function automatic logic [7:0] fr_err_code(input logic [3:0] e);
    case (fr_pkg::fr_rxerr_t'(e))
      fr_pkg::E_SOFH:   fr_err_code = `FR_RC_SOFH;
      fr_pkg::E_SOFL:   fr_err_code = `FR_RC_SOFL;
      fr_pkg::E_GUARD:  fr_err_code = `FR_RC_GUARD;
      fr_pkg::E_TRS:    fr_err_code = `FR_RC_TRS;
      fr_pkg::E_WAIT:   fr_err_code = `FR_RC_WAIT;
      fr_pkg::E_BADSOF: fr_err_code = `FR_RC_BADSOF;
      fr_pkg::E_DROP:   fr_err_code = `FR_RC_DROP;
      fr_pkg::E_FRAME:  fr_err_code = `FR_RC_FRAMING;
      fr_pkg::E_CRC:    fr_err_code = `FR_RC_CRC;
      default:          fr_err_code = `FR_RC_INTERNAL;
    endcase
  endfunction : fr_err_code

  fr_pkg::fr_state_t state_reg, state_next;
  logic [7:0]  buf_mem [0:`FR_BUF_DEPTH-1];
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  cmd_reg, cmd_next, len_reg, len_next;
  logic [9:0]  idx_reg, idx_next, rpl_len_reg, rpl_len_next;
  logic [7:0]  code_reg, code_next;
  logic [15:0] pay_reg, pay_next;
  logic        rpl_one_reg, rpl_one_next, rpl_pay_reg, rpl_pay_next;
  logic        ovf_reg, ovf_next;
  logic [3:0]  mask_reg, mask_next, wevt_reg, wevt_next;
  logic [7:0]  proto_reg, proto_next, param_reg, param_next;
  logic [7:0]  acfg_reg, acfg_next, aidx_reg, aidx_next, tw_reg, tw_next;
  logic        adf_reg, adf_next, acf_reg, acf_next;
  logic        txv_reg, txv_next, txl_reg, txl_next;
  logic [7:0]  txd_reg, txd_next;
  logic [1:0]  field_ff;
  logic [3:0]  wake_ff1, wake_ff2;

  // register bus decode
  wire       req     = avs_read_i | avs_write_i;
  wire       acc     = req & ~wait_reg;
  wire       wr_cmd  = acc & avs_write_i & avs_byteenable_i[0] & (avs_address_i == `FR_OFS_CMD);
  wire       wr_ctl  = acc & avs_write_i & avs_byteenable_i[0] & (avs_address_i == `FR_OFS_CTRL);
  wire       rd_rpl  = acc & avs_read_i & (avs_address_i == `FR_OFS_REPLY);
  wire [7:0] hb      = avs_writedata_i[7:0];
  wire       abort   = wr_ctl & hb[0];
  wire       field_s = field_ff[1];

  // reply byte selection
  wire [9:0] bidx     = idx_reg - 10'd2;
  wire [7:0] pay_byte = (idx_reg == 10'd2) ? pay_reg[7:0] : pay_reg[15:8];
  wire [7:0] rpl_byte = (idx_reg == 10'd0) ? code_reg :
                        (idx_reg == 10'd1) ? rpl_len_reg[7:0] :
                        rpl_pay_reg ? pay_byte : buf_mem[bidx];
  wire       rpl_last = rpl_one_reg | (idx_reg == rpl_len_reg + 10'd1);

  // receive limits and result coding
  wire       is_a    = (proto_reg == `FR_P_A) | (proto_reg == `FR_P_CE);
  wire [9:0] lim     = is_a ? `FR_MAX_A : `FR_MAX_LONG;
  wire       rx_full = idx_reg >= lim;
  wire       rx_err  = rf_rx_err_i != 4'h0;
  wire       rx_shrt = (proto_reg == `FR_P_F) & (idx_reg < `FR_MIN_F);
  wire       rx_bad  = rx_err | ovf_reg | rx_shrt;
  wire [7:0] rx_code = rx_err  ? fr_err_code(rf_rx_err_i) :
                       ovf_reg ? `FR_RC_FULL :
                       rx_shrt ? `FR_RC_SHORT :
                       {1'b1, idx_reg[9:8], rf_rx_partial_i & is_a, 4'h0};
  wire       in_rx   = (state_reg == fr_pkg::S_RX) | (state_reg == fr_pkg::S_LISTEN);
  wire       in_data = state_reg == fr_pkg::S_DATA;
  wire       buf_we  = (in_data & wr_cmd) | (in_rx & rf_rx_valid_i & ~rx_full);
  wire [7:0] buf_wd  = in_data ? hb : rf_rx_data_i;
  wire [7:0] b0      = buf_mem[0];
  wire [7:0] b1      = buf_mem[1];
  wire [3:0] wake_hit = wake_ff2 & mask_reg;
  wire       proto_ok = (b0 <= `FR_P_F) | (b0 == `FR_P_CE);
  wire       tx_acc  = txv_reg & rf_tx_ready_i;

  wire [31:0] rd_mux =
    (avs_address_i == `FR_OFS_REPLY)  ? {23'h0, state_reg == fr_pkg::S_REPLY, rpl_byte} :
    (avs_address_i == `FR_OFS_STATUS) ? {16'h0, proto_reg, 3'h0, field_s, low_power_o,
                                         rf_listen_o, state_reg == fr_pkg::S_REPLY,
                                         state_reg == fr_pkg::S_IDLE} :
    (avs_address_i == `FR_OFS_CFG)    ? {6'h0, acf_reg, adf_reg, tw_reg, aidx_reg, acfg_reg} :
    32'h0;

  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    len_next = len_reg;
    idx_next = idx_reg;
    rpl_len_next = rpl_len_reg;
    code_next = code_reg;
    pay_next = pay_reg;
    rpl_one_next = rpl_one_reg;
    rpl_pay_next = rpl_pay_reg;
    ovf_next = ovf_reg;
    mask_next = mask_reg;
    wevt_next = wevt_reg;
    proto_next = proto_reg;
    param_next = param_reg;
    acfg_next = acfg_reg;
    aidx_next = aidx_reg;
    tw_next = tw_reg;
    adf_next = adf_reg;
    acf_next = acf_reg;
    txv_next = txv_reg;
    txl_next = txl_reg;
    txd_next = txd_reg;
    unique case (state_reg)
      fr_pkg::S_IDLE: if (wr_cmd) begin
        if (hb == `FR_CMD_ECHO) begin
          code_next = `FR_CMD_ECHO;
          rpl_one_next = 1'b1;
          idx_next = 10'd0;
          state_next = fr_pkg::S_REPLY;
        end else begin
          cmd_next = hb;
          state_next = fr_pkg::S_LEN;
        end
      end
      fr_pkg::S_LEN: if (wr_cmd) begin
        len_next = hb;
        idx_next = 10'd0;
        state_next = (hb == 8'h00) ? fr_pkg::S_EXEC : fr_pkg::S_DATA;
      end
      fr_pkg::S_DATA: if (wr_cmd) begin
        idx_next = idx_reg + 10'd1;
        if (idx_reg == {2'b00, len_reg} - 10'd1) state_next = fr_pkg::S_EXEC;
      end
      fr_pkg::S_EXEC: begin
        state_next = fr_pkg::S_REPLY;
        idx_next = 10'd0;
        rpl_one_next = 1'b0;
        rpl_pay_next = 1'b1;
        rpl_len_next = 10'd0;
        code_next = `FR_RC_OK;
        ovf_next = 1'b0;
        case (cmd_reg)
          `FR_CMD_IDENT: begin
            rpl_len_next = 10'd2;
            pay_next = {ID_REV, ID_CODE};
          end
          `FR_CMD_PROTO:
            if (len_reg == 8'h00) code_next = `FR_RC_BADLEN;
            else if (!proto_ok) code_next = `FR_RC_BADPROTO;
            else begin
              proto_next = b0;
              param_next = (len_reg > 8'h01) ? b1 : 8'h00;
            end
          `FR_CMD_FIELD: begin
            rpl_len_next = 10'd1;
            pay_next = {15'h0, field_s};
          end
          `FR_CMD_XFER, `FR_CMD_SEND:
            if ((cmd_reg == `FR_CMD_XFER) == ((proto_reg == `FR_P_OFF) | (proto_reg == `FR_P_CE)) ||
                (cmd_reg == `FR_CMD_SEND && proto_reg != `FR_P_CE))
              code_next = `FR_RC_BADPROTO;
            else if (len_reg != 8'h00) begin
              txv_next = 1'b1;
              txd_next = b0;
              txl_next = len_reg == 8'h01;
              state_next = fr_pkg::S_TX;
            end else if (cmd_reg == `FR_CMD_XFER) state_next = fr_pkg::S_RX;
          `FR_CMD_LISTEN:
            if (proto_reg != `FR_P_CE) code_next = `FR_RC_BADPROTO;
            else if (!field_s) code_next = `FR_RC_NOFIELD;
            else state_next = fr_pkg::S_LISTEN;
          `FR_CMD_IDLE:
            if (len_reg == 8'h00) code_next = `FR_RC_BADLEN;
            else begin
              mask_next = b0[3:0];
              state_next = fr_pkg::S_WFE;
            end
          `FR_CMD_REGISTER_READ_CMD: begin
            rpl_len_next = 10'd1;
            pay_next = {8'h00, (b0 == 8'h00) ? {4'h0, wevt_reg} : acfg_reg};
          end
          `FR_CMD_REGISTER_WRITE_CMD:
            if (len_reg < 8'h02) code_next = `FR_RC_BADLEN;
            else case (b0)
              8'h00: acfg_next = b1;
              8'h01: aidx_next = b1;
              8'h02: tw_next = b1;
              8'h03: adf_next = b1[0];
              default: code_next = `FR_RC_BADLEN;
            endcase
          `FR_CMD_SUBC: begin
            rpl_len_next = 10'd1;
            pay_next = {8'h00, rf_subcarrier_i};
          end
          `FR_CMD_ACF:
            if (len_reg == 8'h00) code_next = `FR_RC_BADLEN;
            else acf_next = b0[0];
          default: code_next = `FR_RC_INTERNAL;
        endcase
      end
      fr_pkg::S_TX: if (tx_acc) begin
        if (txl_reg) begin
          txv_next = 1'b0;
          txl_next = 1'b0;
          idx_next = 10'd0;
          state_next = (cmd_reg == `FR_CMD_SEND) ? fr_pkg::S_REPLY : fr_pkg::S_RX;
        end else begin
          idx_next = idx_reg + 10'd1;
          txd_next = buf_mem[idx_reg + 10'd1];
          txl_next = idx_reg + 10'd2 == {2'b00, len_reg};
        end
      end
      fr_pkg::S_RX, fr_pkg::S_LISTEN: begin
        rpl_pay_next = 1'b0;
        if (state_reg == fr_pkg::S_LISTEN && wr_cmd && hb == `FR_CMD_ECHO) begin
          code_next = `FR_CMD_ECHO;
          rpl_one_next = 1'b1;
          idx_next = 10'd0;
          state_next = fr_pkg::S_REPLY;
        end else if (state_reg == fr_pkg::S_LISTEN && abort) begin
          code_next = `FR_RC_ABORT;
          rpl_len_next = 10'd0;
          idx_next = 10'd0;
          state_next = fr_pkg::S_REPLY;
        end else if (rf_rx_done_i) begin
          code_next = rx_code;
          rpl_len_next = rx_bad ? 10'd0 : idx_reg;
          idx_next = 10'd0;
          state_next = fr_pkg::S_REPLY;
        end else if (rf_rx_valid_i) begin
          if (rx_full) ovf_next = 1'b1;
          else idx_next = idx_reg + 10'd1;
        end
      end
      fr_pkg::S_WFE: if (wake_hit != 4'h0) begin
        wevt_next = wake_hit;
        pay_next = {12'h000, wake_hit};
        rpl_len_next = 10'd1;
        idx_next = 10'd0;
        state_next = fr_pkg::S_REPLY;
      end
      fr_pkg::S_REPLY: if (rd_rpl) begin
        if (rpl_last) begin
          idx_next = 10'd0;
          rpl_one_next = 1'b0;
          state_next = fr_pkg::S_IDLE;
        end else idx_next = idx_reg + 10'd1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    field_ff <= {field_ff[0], external_field_flag_i};
    wake_ff1 <= wake_src_i;
    wake_ff2 <= wake_ff1;
    if (buf_we) buf_mem[idx_reg] <= buf_wd;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
      state_reg <= fr_pkg::S_IDLE;
      {cmd_reg, len_reg, code_reg, idx_reg, rpl_len_reg} <= '0;
      {pay_reg, rpl_one_reg, rpl_pay_reg, ovf_reg, mask_reg, wevt_reg} <= '0;
      {param_reg, acfg_reg, aidx_reg, tw_reg, adf_reg, acf_reg} <= '0;
      proto_reg <= `FR_P_OFF;
      {txv_reg, txl_reg, txd_reg, rf_listen_o, low_power_o} <= '0;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (req & wait_reg) rdata_reg <= rd_mux;
      state_reg <= state_next;
      {cmd_reg, len_reg, code_reg, idx_reg, rpl_len_reg} <=
        {cmd_next, len_next, code_next, idx_next, rpl_len_next};
      {pay_reg, rpl_one_reg, rpl_pay_reg, ovf_reg, mask_reg, wevt_reg} <=
        {pay_next, rpl_one_next, rpl_pay_next, ovf_next, mask_next, wevt_next};
      {proto_reg, param_reg, acfg_reg, aidx_reg, tw_reg, adf_reg, acf_reg} <=
        {proto_next, param_next, acfg_next, aidx_next, tw_next, adf_next, acf_next};
      {txv_reg, txl_reg, txd_reg} <= {txv_next, txl_next, txd_next};
      rf_listen_o <= state_next == fr_pkg::S_LISTEN;
      low_power_o <= state_next == fr_pkg::S_WFE;
    end
  end

  assign avs_waitrequest_o     = wait_reg;
  assign avs_readdata_o        = rdata_reg;
  assign rf_tx_valid_o         = txv_reg;
  assign rf_tx_data_o          = txd_reg;
  assign rf_tx_last_o          = txl_reg;
  assign rf_proto_o            = proto_reg;
  assign rf_param_o            = param_reg;
  assign analog_cfg_o          = acfg_reg;
  assign analog_index_o        = aidx_reg;
  assign type_a_timer_window_o = tw_reg;
  assign autodetect_en_o       = adf_reg;
  assign ac_filter_en_o        = acf_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  wire rx_end = in_rx & rf_rx_done_i & ~(state_reg == fr_pkg::S_LISTEN & (abort | (wr_cmd & hb == `FR_CMD_ECHO)));
  sequence s_tx_final;
    (state_reg == fr_pkg::S_TX) && tx_acc && txl_reg && cmd_reg == `FR_CMD_XFER;
  endsequence
  sequence s_rx_armed;
    state_reg == fr_pkg::S_RX && idx_reg == 10'd0 && !rf_tx_valid_o;
  endsequence

  a_echo_reply: assert property ((state_reg == fr_pkg::S_IDLE) && wr_cmd && hb == `FR_CMD_ECHO |=>
    state_reg == fr_pkg::S_REPLY && code_reg == `FR_CMD_ECHO && rpl_one_reg)
    else $error("echo not answered with single echo byte");
  a_long_code_form: assert property (rx_end && !rx_bad |=>
    code_reg[7] && code_reg[3:0] == 4'h0 && (code_reg[4] -> is_a))
    else $error("long frame code malformed");
  a_len_split: assert property (rx_end && !rx_bad |=>
    {code_reg[6:5], rpl_len_reg[7:0]} == $past(idx_reg) && rpl_len_reg == $past(idx_reg))
    else $error("received count not split over code and length");
  a_full_code: assert property (rx_end && !rx_err && ovf_reg |=> code_reg == `FR_RC_FULL)
    else $error("overflow not reported");
  a_wait_code: assert property (rx_end && rf_rx_err_i == 4'h5 |=> code_reg == `FR_RC_WAIT)
    else $error("wait expiry not reported");
  a_unknown_cmd: assert property ((state_reg == fr_pkg::S_EXEC) && cmd_reg == 8'h0a |=>
    code_reg == `FR_RC_INTERNAL && rpl_len_reg == 10'd0 && state_reg == fr_pkg::S_REPLY)
    else $error("reserved code not refused");
  a_field_value: assert property ((state_reg == fr_pkg::S_EXEC) && cmd_reg == `FR_CMD_FIELD |=>
    pay_reg[0] == $past(field_s) && rpl_len_reg == 10'd1)
    else $error("field flag reply wrong");
  a_proto_store: assert property ((state_reg == fr_pkg::S_EXEC) && cmd_reg == `FR_CMD_PROTO &&
    len_reg != 8'h00 && proto_ok |=> proto_reg == $past(b0) && code_reg == `FR_RC_OK)
    else $error("protocol not stored");
  a_tx_then_rx: assert property (s_tx_final |=> s_rx_armed)
    else $error("transmit end did not arm reception");
  a_limit_hold: assert property (in_rx && rf_rx_valid_i && rx_full && !rf_rx_done_i && !wr_cmd && !abort |=>
    idx_reg == $past(idx_reg))
    else $error("receive count passed limit");

endmodule : fr_host_framer
`default_nettype wire

// [fr_params.svh]
// offsets, command and reply codes, protocol codes and limits of the host framer
`ifndef FR_PARAMS_SVH
`define FR_PARAMS_SVH
`define FR_OFS_CMD      6'h00
`define FR_OFS_REPLY    6'h04
`define FR_OFS_STATUS   6'h08
`define FR_OFS_CTRL     6'h0c
`define FR_OFS_CFG      6'h10
`define FR_CMD_IDENT    8'h01
`define FR_CMD_PROTO    8'h02
`define FR_CMD_FIELD    8'h03
`define FR_CMD_XFER     8'h04
`define FR_CMD_LISTEN   8'h05
`define FR_CMD_SEND     8'h06
`define FR_CMD_IDLE     8'h07
`define FR_CMD_REGISTER_READ_CMD    8'h08
`define FR_CMD_REGISTER_WRITE_CMD    8'h09
`define FR_CMD_SUBC     8'h0b
`define FR_CMD_ACF      8'h0d
`define FR_CMD_ECHO     8'h55
`define FR_RC_OK        8'h00
`define FR_RC_SOFH      8'h63
`define FR_RC_SOFL      8'h65
`define FR_RC_GUARD     8'h66
`define FR_RC_TRS       8'h68
`define FR_RC_INTERNAL  8'h71
`define FR_RC_GOOD      8'h80
`define FR_RC_BADLEN    8'h82
`define FR_RC_BADPROTO  8'h83
`define FR_RC_ABORT     8'h85
`define FR_RC_WAIT      8'h87
`define FR_RC_BADSOF    8'h88
`define FR_RC_FULL      8'h89
`define FR_RC_FRAMING   8'h8a
`define FR_RC_SHORT     8'h8c
`define FR_RC_CRC       8'h8d
`define FR_RC_DROP      8'h8e
`define FR_RC_NOFIELD   8'h8f
`define FR_P_OFF        8'h00
`define FR_P_V          8'h01
`define FR_P_A          8'h02
`define FR_P_B          8'h03
`define FR_P_F          8'h04
`define FR_P_CE         8'h12
`define FR_MAX_LONG     10'd528
`define FR_MAX_A        10'd256
`define FR_MIN_F        10'd3
`define FR_BUF_DEPTH    528
`endif

// [fr_pkg.sv]
// types of the host framer: controller states and receive error classes
package fr_pkg;
  typedef enum logic [8:0] {
    S_IDLE   = 9'h001,
    S_LEN    = 9'h002,
    S_DATA   = 9'h004,
    S_EXEC   = 9'h008,
    S_TX     = 9'h010,
    S_RX     = 9'h020,
    S_LISTEN = 9'h040,
    S_WFE    = 9'h080,
    S_REPLY  = 9'h100
  } fr_state_t;
  typedef enum logic [3:0] {
    E_NONE, E_SOFH, E_SOFL, E_GUARD, E_TRS, E_WAIT, E_BADSOF, E_DROP, E_FRAME, E_CRC
  } fr_rxerr_t;
endpackage : fr_pkg

// [fr_rf_peer.sv]
// behavioural rf engine facing the framer: takes tx bytes, answers with a counted frame
`timescale 1ns/1ps
`default_nettype none
module fr_rf_peer (
  input  wire logic       clk_sys_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  input  wire logic       stall_i,
  input  wire logic [9:0] rsp_len_i,
  input  wire logic [3:0] rsp_err_i,
  input  wire logic       rsp_partial_i,
  output logic            tx_ready_o,
  output logic            rx_valid_o = 1'b0,
  output logic      [7:0] rx_data_o = 8'h00,
  output logic            rx_done_o = 1'b0,
  output logic      [3:0] rx_err_o = 4'h0,
  output logic            rx_partial_o = 1'b0
);
  logic       busy_reg = 1'b0;
  logic       tick_reg = 1'b0;
  logic [9:0] idx_reg  = 10'h000;
  // slow mode accepts only every other cycle
  assign tx_ready_o = ~busy_reg & (~stall_i | tick_reg);
  always_ff @(posedge clk_sys_i) begin
    tick_reg     <= ~tick_reg;
    rx_valid_o   <= 1'b0;
    rx_done_o    <= 1'b0;
    // qualified lines carry junk outside their strobes
    rx_data_o    <= ~rx_data_o;
    rx_err_o     <= ~rx_err_o;
    rx_partial_o <= ~rx_partial_o;
    if (tx_valid_i && tx_ready_o && tx_last_i) begin
      busy_reg <= 1'b1;
      idx_reg  <= 10'h000;
    end else if (busy_reg && idx_reg == rsp_len_i) begin
      busy_reg     <= 1'b0;
      rx_done_o    <= 1'b1;
      rx_err_o     <= rsp_err_i;
      rx_partial_o <= rsp_partial_i;
    end else if (busy_reg) begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= idx_reg[7:0];
      idx_reg    <= idx_reg + 10'h001;
    end
  end
endmodule : fr_rf_peer
`default_nettype wire

// [nfc_host_command_framer_bench.sv]
// self-checking bench of the host command framer
`timescale 1ns/1ps
`default_nettype none
`include "fr_params.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module nfc_host_command_framer_bench;
  logic        clk_sys_i = 1'b0, rstn_i = 1'b0, rd = 1'b0, wr = 1'b0, wreq, tx_v, tx_r, tx_l, rx_v, rx_d, rx_p;
  logic        field = 1'b0, part = 1'b0, stall = 1'b0, lst, lp, acf, adf;
  logic [7:0]  prm, aix, tmw;
  logic [8:0]  txq[$];
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [7:0]  tx_dat, rx_dat, proto, acfg, subc = 8'h00, xq[$];
  logic [3:0]  rx_e, wake = 4'h0, err = 4'h0;
  logic [9:0]  rlen = 10'h000;
  logic [7:0]  ecode[9] = '{`FR_RC_SOFH, `FR_RC_SOFL, `FR_RC_GUARD, `FR_RC_TRS, `FR_RC_WAIT, `FR_RC_BADSOF,
                            `FR_RC_DROP, `FR_RC_FRAMING, `FR_RC_CRC};
  int          num_errors = 0, n_compared = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  fr_host_framer i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'h1), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .rf_tx_valid_o(tx_v), .rf_tx_ready_i(tx_r), .rf_tx_data_o(tx_dat),
    .rf_tx_last_o(tx_l), .rf_rx_valid_i(rx_v), .rf_rx_data_i(rx_dat), .rf_rx_done_i(rx_d), .rf_rx_err_i(rx_e),
    .rf_rx_partial_i(rx_p), .rf_subcarrier_i(subc), .rf_listen_o(lst), .external_field_flag_i(field),
    .wake_src_i(wake), .rf_proto_o(proto), .rf_param_o(prm), .analog_cfg_o(acfg), .analog_index_o(aix),
    .type_a_timer_window_o(tmw), .autodetect_en_o(adf), .ac_filter_en_o(acf), .low_power_o(lp));
  fr_rf_peer i_peer (.clk_sys_i(clk_sys_i), .tx_valid_i(tx_v), .tx_last_i(tx_l), .stall_i(stall),
    .rsp_len_i(rlen), .rsp_err_i(err), .rsp_partial_i(part), .tx_ready_o(tx_r), .rx_valid_o(rx_v),
    .rx_data_o(rx_dat), .rx_done_o(rx_d), .rx_err_o(rx_e), .rx_partial_o(rx_p));
  // log of every byte the rf side accepted, with its last flag
  always @(posedge clk_sys_i) if (tx_v && tx_r) txq.push_back({tx_l, tx_dat});
  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    adr <= a; wdat <= {24'h0, d}; wr <= w; rd <= ~w;
    do begin @(posedge clk_sys_i); k++; end while (wreq !== 1'b0 && k < 50);
    q = rdat;
    wr <= 1'b0; rd <= 1'b0;
    if (k >= 50) `CHK("waitrequest", 1'b0, wreq)
  endtask : bus
  task automatic cmd(input logic [7:0] c, input logic [7:0] n, input logic [7:0] b0, input logic [7:0] b1);
    bus(1'b1, `FR_OFS_CMD, c);
    if (c != `FR_CMD_ECHO) bus(1'b1, `FR_OFS_CMD, n);
    if (n > 0) bus(1'b1, `FR_OFS_CMD, b0);
    if (n > 1) bus(1'b1, `FR_OFS_CMD, b1);
  endtask : cmd
  // waits for a reply and reads it whole; data default to the peer's counting pattern
  task automatic rpl(input logic [7:0] c, input logic [9:0] n);
    int k;
    k = 0;
    do begin bus(1'b0, `FR_OFS_STATUS, 8'h00); k++; end while (q[1] !== 1'b1 && k < 2000);
    bus(1'b0, `FR_OFS_REPLY, 8'h00); `CHK("code", {1'b1, c}, q[8:0])
    if (c != `FR_CMD_ECHO) begin
      bus(1'b0, `FR_OFS_REPLY, 8'h00); `CHK("length", {1'b1, n[7:0]}, q[8:0])
      for (int i = 0; i < n; i++) begin
        bus(1'b0, `FR_OFS_REPLY, 8'h00); `CHK("data", {1'b1, (xq.size() > i) ? xq[i] : i[7:0]}, q[8:0])
      end
    end
    bus(1'b0, `FR_OFS_REPLY, 8'h00); `CHK("drained", 1'b0, q[8])
    xq = {};
  endtask : rpl
  task automatic sel(input logic [7:0] p);
    cmd(`FR_CMD_PROTO, 8'h02, p, 8'h07); rpl(`FR_RC_OK, 10'd0);
    `CHK("protocol", p, proto)
    `CHK("param", 8'h07, prm)
  endtask : sel
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    bus(1'b0, `FR_OFS_STATUS, 8'h00); `CHK("ready", 9'h001, {q[15:8], q[0]})
    bus(1'b0, 6'h3c, 8'h00); `CHK("unmapped", 32'h0, q)
    cmd(`FR_CMD_ECHO, 8'h00, 8'h00, 8'h00); rpl(`FR_CMD_ECHO, 10'd0);
    xq = {8'ha5, 8'h01}; cmd(`FR_CMD_IDENT, 8'h00, 8'h00, 8'h00); rpl(`FR_RC_OK, 10'd2);
    field <= 1'b1; repeat (3) @(posedge clk_sys_i);
    xq = {8'h01}; cmd(`FR_CMD_FIELD, 8'h00, 8'h00, 8'h00); rpl(`FR_RC_OK, 10'd1);
    cmd(8'h0a, 8'h00, 8'h00, 8'h00); rpl(`FR_RC_INTERNAL, 10'd0);
    cmd(`FR_CMD_XFER, 8'h01, 8'h33, 8'h00); rpl(`FR_RC_BADPROTO, 10'd0);
    cmd(`FR_CMD_PROTO, 8'h01, 8'h07, 8'h00); rpl(`FR_RC_BADPROTO, 10'd0);
    cmd(`FR_CMD_PROTO, 8'h00, 8'h00, 8'h00); rpl(`FR_RC_BADLEN, 10'd0);
    cmd(`FR_CMD_LISTEN, 8'h00, 8'h00, 8'h00); rpl(`FR_RC_BADPROTO, 10'd0);
    cmd(`FR_CMD_REGISTER_WRITE_CMD, 8'h02, 8'h00, 8'h3c); rpl(`FR_RC_OK, 10'd0); `CHK("analog", 8'h3c, acfg)
    cmd(`FR_CMD_REGISTER_WRITE_CMD, 8'h02, 8'h01, 8'h11); rpl(`FR_RC_OK, 10'd0);
    cmd(`FR_CMD_REGISTER_WRITE_CMD, 8'h02, 8'h02, 8'h22); rpl(`FR_RC_OK, 10'd0);
    cmd(`FR_CMD_REGISTER_WRITE_CMD, 8'h02, 8'h03, 8'h01); rpl(`FR_RC_OK, 10'd0);
    cmd(`FR_CMD_REGISTER_WRITE_CMD, 8'h02, 8'h04, 8'h55); rpl(`FR_RC_BADLEN, 10'd0);
    xq = {8'h3c}; cmd(`FR_CMD_REGISTER_READ_CMD, 8'h01, 8'h01, 8'h00); rpl(`FR_RC_OK, 10'd1);
    cmd(`FR_CMD_ACF, 8'h01, 8'h01, 8'h00); rpl(`FR_RC_OK, 10'd0); `CHK("filter", 1'b1, acf)
    cmd(`FR_CMD_ACF, 8'h00, 8'h00, 8'h00); rpl(`FR_RC_BADLEN, 10'd0);
    bus(1'b0, `FR_OFS_CFG, 8'h00); `CHK("config", 32'h0322113c, q)
    `CHK("config pins", {8'h11, 8'h22, 1'b1}, {aix, tmw, adf})
    subc <= 8'h5a; xq = {8'h5a}; cmd(`FR_CMD_SUBC, 8'h00, 8'h00, 8'h00); rpl(`FR_RC_OK, 10'd1);
    sel(`FR_P_F); rlen <= 10'd3;
    for (int e = 1; e < 10; e++) begin
      err <= e[3:0]; cmd(`FR_CMD_XFER, 8'h01, 8'h33, 8'h00); rpl(ecode[e-1], 10'd0);
    end
    err <= 4'h0; rlen <= 10'd2; cmd(`FR_CMD_XFER, 8'h01, 8'h33, 8'h00); rpl(`FR_RC_SHORT, 10'd0);
    rlen <= 10'd3; stall <= 1'b1; cmd(`FR_CMD_XFER, 8'h02, 8'h33, 8'h34); rpl(`FR_RC_GOOD, 10'd3);
    `CHK("tx bytes", {1'b0, 8'h33, 1'b1, 8'h34}, {txq[txq.size()-2], txq[txq.size()-1]})
    `CHK("tx count", 12, txq.size())
    sel(`FR_P_A); part <= 1'b1; rlen <= 10'd5; cmd(`FR_CMD_XFER, 8'h01, 8'h26, 8'h00); rpl(8'h90, 10'd5);
    part <= 1'b0; rlen <= 10'd257; cmd(`FR_CMD_XFER, 8'h01, 8'h26, 8'h00); rpl(`FR_RC_FULL, 10'd0);
    sel(`FR_P_B); part <= 1'b1; rlen <= 10'd528; cmd(`FR_CMD_XFER, 8'h01, 8'h05, 8'h00); rpl(8'hc0, 10'd528);
    sel(`FR_P_CE); field <= 1'b0; repeat (3) @(posedge clk_sys_i);
    cmd(`FR_CMD_LISTEN, 8'h00, 8'h00, 8'h00); rpl(`FR_RC_NOFIELD, 10'd0);
    field <= 1'b1; repeat (3) @(posedge clk_sys_i);
    cmd(`FR_CMD_LISTEN, 8'h00, 8'h00, 8'h00); repeat (3) @(posedge clk_sys_i); `CHK("listen", 1'b1, lst)
    bus(1'b1, `FR_OFS_CTRL, 8'h01); rpl(`FR_RC_ABORT, 10'd0);
    cmd(`FR_CMD_LISTEN, 8'h00, 8'h00, 8'h00); cmd(`FR_CMD_ECHO, 8'h00, 8'h00, 8'h00);
    rpl(`FR_CMD_ECHO, 10'd0); `CHK("listen off", 1'b0, lst)
    rlen <= 10'd0; cmd(`FR_CMD_SEND, 8'h01, 8'h44, 8'h00); rpl(`FR_RC_OK, 10'd0);
    cmd(`FR_CMD_IDLE, 8'h01, 8'h02, 8'h00); repeat (5) @(posedge clk_sys_i); `CHK("low power", 1'b1, lp)
    wake <= 4'h6; xq = {8'h02}; rpl(`FR_RC_OK, 10'd1); `CHK("awake", 1'b0, lp)
    xq = {8'h02}; cmd(`FR_CMD_REGISTER_READ_CMD, 8'h01, 8'h00, 8'h00); rpl(`FR_RC_OK, 10'd1);
    end_sim();
  end
endmodule : nfc_host_command_framer_bench
`default_nettype wire
